// file: core/scg_core.sv
// System clock generator: fuse-driven source select, start-up delays,
// timed-unlock prescaler, clock-out pin and PLL reference divider.
// Assumes an Avalon-MM master with waitrequest and fuse straps stable in reset.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "scg_regs.svh"

module scg_core #(
   parameter int unsigned RST_MID_CYC  = `SCG_T_MID_US * `SCG_CLK_MHZ,
   parameter int unsigned RST_LONG_CYC = `SCG_T_LONG_US * `SCG_CLK_MHZ
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic [`SCG_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   input  wire scg_pkg::scg_fuse_t     fuse_in,
   input  wire logic                   fuse_valid,
   input  wire logic [7:0]             factory_cal,
   input  wire logic                   wake_req,
   output logic                        sys_tick_q,
   output logic                        clock_out_pin_q,
   output logic                        clock_out_oe_q,
   output logic [7:0]                  rc_trim_q,
   output scg_pkg::scg_osc_t           osc_ctl_q,
   output logic                        reset_done_q,
   output logic                        wake_done_q,
   output logic                        pll_ref_q,
   output logic [2:0]                  pll_mult_q
);

   localparam int CW = 22;

   // Captured fuses and register state
   scg_pkg::scg_fuse_t fuse_q;
   scg_pkg::scg_rdly_t rd_state_q;
   logic [CW-1:0]      rd_cnt_q;
   logic [3:0]         divsel_q;
   logic               pce_q;
   logic [2:0]         pce_cnt_q;
   logic [1:0]         rc_sut_q;
   logic [1:0]         ext_sut_q;
   logic [7:0]         plldiv_q;
   logic [2:0]         wake_cnt_q;
   logic               ps_pin;

   // blank fuses read as factory default
   wire scg_pkg::scg_fuse_t def_fuse = '{src: `SCG_DEF_SRC, startup_time_fuses: `SCG_DEF_SUT,
                                        div8: `SCG_DEF_DIV8, clock_output_fuse: `SCG_DEF_CLOCK_OUTPUT_FUSE};
   wire scg_pkg::scg_fuse_t eff_fuse = fuse_valid ? fuse_in : def_fuse;

   wire eff_is_rc = (eff_fuse.src == `SCG_SRC_RC);

   // Bus decode
   wire hit_ps  = (avs_address == `SCG_BYTE_ADDR(`SCG_IDX_PRESCALE));
   wire hit_tr  = (avs_address == `SCG_BYTE_ADDR(`SCG_IDX_TRIM));
   wire hit_cs  = (avs_address == `SCG_BYTE_ADDR(`SCG_IDX_CLKSEL));
   wire hit_st  = (avs_address == `SCG_BYTE_ADDR(`SCG_IDX_STATUS));
   wire hit_pd  = (avs_address == `SCG_BYTE_ADDR(`SCG_IDX_PLLDIV));
   wire wr_ok   = avs_write & ~avs_waitrequest & avs_byteenable[0];
   wire [7:0] wd = avs_writedata[7:0];
   wire ps_wr   = wr_ok & hit_ps;
   wire unlock_wr = (wd == `SCG_UNLOCK_VAL);
   wire value_wr  = ~wd[`SCG_PCE_BIT] & pce_q;

   // Readback; unmapped addresses read zero
   wire [7:0] cs_val = {rc_sut_q, ext_sut_q, osc_ctl_q.rc_en, osc_ctl_q.ext_en,
                        1'b0, osc_ctl_q.sel_ext};
   wire [7:0] st_val = {3'h0, pce_q, fuse_q.startup_time_fuses, ~eff_is_rc, reset_done_q};
   wire [7:0] rd_val = hit_ps ? {pce_q, 3'h0, divsel_q} :
                       hit_tr ? rc_trim_q :
                       hit_cs ? cs_val :
                       hit_st ? st_val :
                       hit_pd ? plldiv_q : 8'h00;

   // Prescale factor; reserved codes hold the slowest setting
   wire [8:0] ps_n = (divsel_q <= `SCG_PS_MAX) ? (9'h001 << divsel_q) : 9'h100;

   // Extra reset delay picked by start-up code; reserved code takes the longest
   wire [CW-1:0] extra_cyc = (fuse_q.startup_time_fuses == `SCG_SUT_MID) ? CW'(RST_MID_CYC) :
                             CW'(RST_LONG_CYC);
   wire base_end  = (rd_cnt_q == CW'(`SCG_RST_CK - 5'h01));
   wire extra_end = (rd_cnt_q == extra_cyc - CW'(1));

   // Avalon slave: one wait cycle, then the access completes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest)
            avs_readdata <= {24'h00_0000, rd_val};
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rc_trim_q <= factory_cal;
         fuse_q    <= eff_fuse;
      end
      else if (wr_ok & hit_tr)
         rc_trim_q <= wd;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rc_sut_q  <= 2'h0;
         ext_sut_q <= 2'h0;
         osc_ctl_q <= '{rc_en: eff_is_rc, ext_en: ~eff_is_rc, sel_ext: ~eff_is_rc};
      end
      else if (wr_ok & hit_cs)
      begin
         rc_sut_q  <= wd[`SCG_CS_RC_STARTUP_CODE_HI:`SCG_CS_RC_STARTUP_CODE_LO];
         ext_sut_q <= wd[`SCG_CS_EXTERNAL_STARTUP_CODE_HI:`SCG_CS_EXTERNAL_STARTUP_CODE_LO];
         osc_ctl_q <= '{rc_en: wd[`SCG_CS_RCE_BIT], ext_en: wd[`SCG_CS_EXTERNAL_OSC_ENABLE_BIT],
                        sel_ext: wd[`SCG_CS_SEL_BIT]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pce_q     <= 1'b0;
         pce_cnt_q <= 3'h0;
         divsel_q  <= eff_fuse.div8 ? `SCG_PS_DIV8 : `SCG_PS_NODIV;
      end
      else if (ps_wr & value_wr)
      begin
         divsel_q <= wd[3:0];
         pce_q    <= 1'b0;
         pce_cnt_q <= 3'h0;
      end
      else if (ps_wr & unlock_wr & ~pce_q)
      begin
         pce_q     <= 1'b1;
         pce_cnt_q <= `SCG_UNLOCK_CYC;
      end
      else if (pce_q)
      begin
         pce_cnt_q <= pce_cnt_q - 3'h1;
         if (pce_cnt_q == 3'h1)
            pce_q <= 1'b0;
      end
   end

   // time-out counts plain clock
   // Counts on the free-running clock, untouched by source select or prescaler
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_state_q   <= scg_pkg::SCG_RD_BASE;
         rd_cnt_q     <= '0;
         reset_done_q <= 1'b0;
      end
      else
      begin
         case (rd_state_q)
            scg_pkg::SCG_RD_BASE:
            begin
               rd_cnt_q <= rd_cnt_q + CW'(1);
               if (base_end)
               begin
                  rd_cnt_q <= '0;
                  if (fuse_q.startup_time_fuses == `SCG_SUT_BOD)
                  begin
                     rd_state_q   <= scg_pkg::SCG_RD_DONE;
                     reset_done_q <= 1'b1;
                  end
                  else
                     rd_state_q <= scg_pkg::SCG_RD_EXTRA;
               end
            end
            scg_pkg::SCG_RD_EXTRA:
            begin
               rd_cnt_q <= rd_cnt_q + CW'(1);
               if (extra_end)
               begin
                  rd_state_q   <= scg_pkg::SCG_RD_DONE;
                  reset_done_q <= 1'b1;
               end
            end
            default:
            begin
               rd_state_q   <= scg_pkg::SCG_RD_DONE;
               reset_done_q <= 1'b1;
            end
         endcase
      end
   end

   // wake delay of 6 CK
   // Requests while a wake is counting are ignored
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wake_cnt_q  <= 3'h0;
         wake_done_q <= 1'b0;
      end
      else
      begin
         wake_done_q <= (wake_cnt_q == 3'h1);
         if (wake_cnt_q != 3'h0)
            wake_cnt_q <= wake_cnt_q - 3'h1;
         else if (wake_req & reset_done_q)
            wake_cnt_q <= `SCG_WAKE_CK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         clock_out_oe_q <= eff_fuse.clock_output_fuse;
      else
         clock_out_oe_q <= fuse_q.clock_output_fuse;
   end

   // Period lengths and the PLL tick stay inside the dividers
   // system prescaler
   scg_divider #(
      .W (9)
   ) u_ps (
      .clk     (clk),
      .sys_rst (sys_rst),
      .div_n   (ps_n),
      .tick_q  (sys_tick_q),
      .pin_q   (ps_pin),
      .cur_n_q ()
   );

   assign clock_out_pin_q = ps_pin;

   // PLL input prescaler settings
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         plldiv_q   <= `SCG_PLLDIV_RST;
         pll_mult_q <= `SCG_PLL_MULT;
      end
      else
      begin
         pll_mult_q <= `SCG_PLL_MULT;
         // Zero would wrap the divider to a 256-clock period, so it is read as one
         if (wr_ok & hit_pd)
            plldiv_q <= (wd == 8'h00) ? 8'h01 : wd;
      end
   end

   scg_divider #(
      .W (8)
   ) u_pll (
      .clk     (clk),
      .sys_rst (sys_rst),
      .div_n   (plldiv_q),
      .tick_q  (),
      .pin_q   (pll_ref_q),
      .cur_n_q ()
   );

   a_unlock_clear: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(pce_q) |-> ##[1:4] !pce_q)
      else $error("unlock bit outlived four cycles");

   a_unlock_noext: assert property (@(posedge clk) disable iff (sys_rst)
      (pce_q && pce_cnt_q > 3'h1 && ps_wr && unlock_wr)
      |=> pce_q && pce_cnt_q == $past(pce_cnt_q) - 3'h1)
      else $error("unlock rewrite changed the timeout");

   a_div_locked: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(divsel_q) && !$past(sys_rst) |-> $past(pce_q) && $past(ps_wr))
      else $error("division changed without unlock");

   a_div_reset: assert property (@(posedge clk)
      $fell(sys_rst) |-> divsel_q == ($past(eff_fuse.div8) ? `SCG_PS_DIV8 : 4'h0))
      else $error("division reset value wrong");

   a_trim_load: assert property (@(posedge clk)
      $fell(sys_rst) |-> rc_trim_q == $past(factory_cal))
      else $error("trim not loaded from calibration");

   a_src_default: assert property (@(posedge clk)
      $fell(sys_rst) |-> osc_ctl_q.sel_ext == ($past(eff_fuse.src) != `SCG_SRC_RC))
      else $error("source bit reset value wrong");

   a_pin_override: assert property (@(posedge clk) disable iff (sys_rst)
      clock_out_oe_q == fuse_q.clock_output_fuse)
      else $error("clock out enable differs from fuse");

   a_wake_delay: assert property (@(posedge clk) disable iff (sys_rst)
      (wake_req && reset_done_q && wake_cnt_q == 3'h0) |-> ##7 wake_done_q)
      else $error("wake delay not six clocks");

   a_rst_base: assert property (@(posedge clk)
      ($fell(sys_rst) && fuse_q.startup_time_fuses == `SCG_SUT_BOD)
      |-> ##13 !reset_done_q ##1 reset_done_q)
      else $error("base reset delay not fourteen clocks");

endmodule

// file: inc/scg_regs.svh
// Register indices, field positions, reset values and timing counts of the
// system clock generator. Included by the design files; holds defines only.
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

// Register indices; the Avalon byte address is four times the index
`define SCG_IDX_PRESCALE   8'h61
`define SCG_IDX_TRIM       8'h66
`define SCG_IDX_CLKSEL     8'hd0
`define SCG_IDX_STATUS     8'he0
`define SCG_IDX_PLLDIV     8'he1
`define SCG_ADDR_W         10
`define SCG_BYTE_ADDR(i)   {(i), 2'b00}

// Prescale control fields
`define SCG_PCE_BIT        7
`define SCG_UNLOCK_VAL     8'h80
`define SCG_UNLOCK_CYC     3'h4
`define SCG_PS_MAX         4'h8
`define SCG_PS_DIV8        4'h3
`define SCG_PS_NODIV       4'h0

// Clock selection control fields
`define SCG_CS_RC_STARTUP_CODE_HI    7
`define SCG_CS_RC_STARTUP_CODE_LO    6
`define SCG_CS_EXTERNAL_STARTUP_CODE_HI    5
`define SCG_CS_EXTERNAL_STARTUP_CODE_LO    4
`define SCG_CS_RCE_BIT     3
`define SCG_CS_EXTERNAL_OSC_ENABLE_BIT    2
`define SCG_CS_SEL_BIT     0

// Fuse encodings and factory defaults
`define SCG_SRC_RC         4'h2
`define SCG_SUT_BOD        2'h0
`define SCG_SUT_MID        2'h1
`define SCG_SUT_LONG       2'h2
`define SCG_DEF_SRC        4'h2
`define SCG_DEF_SUT        2'h2
`define SCG_DEF_DIV8       1'b1
`define SCG_DEF_CLOCK_OUTPUT_FUSE      1'b0

// Timing
`define SCG_CLK_MHZ        50
`define SCG_WAKE_CK        3'h6
`define SCG_RST_CK         5'h0e
`define SCG_T_MID_US       4100
`define SCG_T_LONG_US      65000
`define SCG_PLL_MULT       3'h6
`define SCG_PLLDIV_RST     8'h01

`endif

// file: inc/scg_pkg.sv
// Types shared by the clock generator files.
// Assumes scg_regs.svh is compiled alongside for the numeric constants.
package scg_pkg;

   // Fuse straps as seen by the clock generator, active high = programmed
   typedef struct packed {
      logic [3:0] src;
      logic [1:0] startup_time_fuses;
      logic       div8;
      logic       clock_output_fuse;
   } scg_fuse_t;

   // Oscillator controls driven to the analog oscillators
   typedef struct packed {
      logic rc_en;
      logic ext_en;
      logic sel_ext;
   } scg_osc_t;

   // Reset time-out sequence
   typedef enum logic [1:0] {
      SCG_RD_BASE,
      SCG_RD_EXTRA,
      SCG_RD_DONE
   } scg_rdly_t;

endpackage

// file: core/scg_divider.sv
// Glitch-free clock divider producing a tick and a toggling pin level.
// Assumes div_n >= 1; a new factor is taken only at a period boundary.
`timescale 1ns/100ps
module scg_divider #(
   parameter int W = 9
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] div_n,
   output logic              tick_q,
   output logic              pin_q,
   output logic [W-1:0]      cur_n_q
);

   logic [W-1:0] count_q;
   logic         armed_q;
   wire          at_end = (count_q == cur_n_q - W'(1));

   // factor swapped at boundary
   // Outside reset the old period always completes, so no short pulse can appear; in reset the pin toggles every clock
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         count_q <= '0;
         cur_n_q <= W'(1);
         tick_q  <= 1'b0;
         armed_q <= 1'b1;
         // Pin keeps running through reset once armed
         if (armed_q)
            pin_q <= ~pin_q;
         else
            pin_q <= 1'b0;
      end
      else if (at_end)
      begin
         count_q <= '0;
         cur_n_q <= div_n;
         tick_q  <= 1'b1;
         pin_q   <= ~pin_q;
      end
      else
      begin
         count_q <= count_q + W'(1);
         tick_q  <= 1'b0;
      end
   end

   a_switch_edge: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(cur_n_q) |-> tick_q)
      else $error("divider factor changed away from a boundary");

   a_tick_single: assert property (@(posedge clk) disable iff (sys_rst)
      (tick_q && cur_n_q > W'(1)) |=> !tick_q)
      else $error("divider produced an extra edge");

endmodule

// file: verification/scg_clk_src.sv
// Source clock model standing in for the external clock at the clock input.
// Assumes the bench takes clk from here; reset is handled by the bench.
`timescale 1ns/100ps
module scg_clk_src (
   output logic clk
);
   initial clk = 1'b0;
   always #10 clk = ~clk;
endmodule

// file: verification/scg_core_tb.sv
// Self-checking bench for scg_core: register map, reset time-outs, wake delay,
// prescaler unlock and division, clock-out pin and PLL reference.
// Assumes scg_clk_src supplies a steady 50 MHz clock.
`timescale 1ns/100ps
`include "scg_regs.svh"
module scg_core_tb;
   typedef struct packed {
      logic       we;
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] mask;
      logic [7:0] exp;
   } scg_row_t;

   localparam int MID  = 20;
   localparam int LONG = 40;

   logic                   clk;
   logic                   sys_rst        = 1'b1;
   logic [`SCG_ADDR_W-1:0] avs_address    = '0;
   logic                   avs_read       = 1'b0;
   logic                   avs_write      = 1'b0;
   logic [31:0]            avs_writedata  = '0;
   logic [3:0]             avs_byteenable = 4'h1;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   scg_pkg::scg_fuse_t     fuse_in        = '0;
   logic                   fuse_valid     = 1'b0;
   logic [7:0]             factory_cal    = 8'h96;
   logic                   wake_req       = 1'b0;
   logic                   sys_tick_q, clock_out_pin_q, clock_out_oe_q;
   logic                   reset_done_q, wake_done_q, pll_ref_q;
   logic [7:0]             rc_trim_q;
   scg_pkg::scg_osc_t      osc_ctl_q;
   logic [2:0]             pll_mult_q;
   int                     n_errors = 0;
   int                     n_tests  = 0;
   int                     cyc      = 0;
   int                     ext [4]  = '{0, MID, LONG, LONG};

   // Reads after reset with blank fuses, then write and read back
   scg_row_t rows [11] = '{
      '{1'b0, 8'h61, 8'h00, 8'hff, 8'h03},
      '{1'b0, 8'h66, 8'h00, 8'hff, 8'ha7},
      '{1'b0, 8'hd0, 8'h00, 8'hff, 8'h08},
      '{1'b0, 8'he0, 8'h00, 8'h1f, 8'h09},
      '{1'b0, 8'he1, 8'h00, 8'hff, 8'h01},
      '{1'b0, 8'h70, 8'h00, 8'hff, 8'h00},
      '{1'b1, 8'h66, 8'h5a, 8'hff, 8'h5a},
      '{1'b1, 8'hd0, 8'hf7, 8'hff, 8'hf5},
      '{1'b1, 8'he1, 8'h00, 8'hff, 8'h01},
      '{1'b1, 8'h61, 8'h05, 8'hff, 8'h03},
      '{1'b1, 8'h70, 8'h55, 8'hff, 8'h00}
   };

   scg_clk_src SRC (.clk(clk));

   scg_core #(
      .RST_MID_CYC  (MID),
      .RST_LONG_CYC (LONG)
   ) DUT (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .fuse_in         (fuse_in),
      .fuse_valid      (fuse_valid),
      .factory_cal     (factory_cal),
      .wake_req        (wake_req),
      .sys_tick_q      (sys_tick_q),
      .clock_out_pin_q (clock_out_pin_q),
      .clock_out_oe_q  (clock_out_oe_q),
      .rc_trim_q       (rc_trim_q),
      .osc_ctl_q       (osc_ctl_q),
      .reset_done_q    (reset_done_q),
      .wake_done_q     (wake_done_q),
      .pll_ref_q       (pll_ref_q),
      .pll_mult_q      (pll_mult_q)
   );

   task automatic stop_test();
      if (n_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      @(posedge clk);
      avs_address   <= `SCG_BYTE_ADDR(idx);
      avs_write     <= we;
      avs_read      <= ~we;
      avs_writedata <= {24'h0, wd};
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [7:0] d;
      bus(1'b1, idx, wd, d);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] m,
                        input logic [7:0] e);
      logic [7:0] d;
      bus(1'b0, idx, 8'h00, d);
      check(nm, d & m, e);
   endtask

   task automatic wait_set(input logic wake, output int n);
      n = 0;
      while ((wake ? wake_done_q : reset_done_q) !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   // Counts edges up to the next tick; a stuck divider ends at the cap
   task automatic tick_gap(output int g, output logic p);
      g = 0;
      do
      begin
         @(posedge clk);
         #1;
         g++;
      end
      while (sys_tick_q !== 1'b1 && g < 600);
      p = clock_out_pin_q;
   endtask

   task automatic do_reset(input scg_pkg::scg_fuse_t f, input logic v, input int extra);
      int   n;
      logic p;
      @(posedge clk);
      sys_rst     <= 1'b1;
      fuse_in     <= f;
      fuse_valid  <= v;
      factory_cal <= factory_cal + 8'h11;
      repeat (11) @(posedge clk);
      #1;
      p = clock_out_pin_q;
      @(posedge clk);
      #1;
      check("pin in reset", clock_out_pin_q, !p);
      check("oe in reset", clock_out_oe_q, f.clock_output_fuse);
      check("trim", rc_trim_q, factory_cal);
      @(posedge clk);
      sys_rst <= 1'b0;
      wait_set(1'b0, n);
      check("reset delay", n, 14 + extra);
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end

   initial
   begin
      int                 n, g, old, nw;
      logic               p, q;
      scg_pkg::scg_fuse_t f;
      do_reset('0, 1'b0, LONG);
      foreach (rows[i])
      begin
         if (rows[i].we)
            wr(rows[i].idx, rows[i].wd);
         rdchk("row", rows[i].idx, rows[i].mask, rows[i].exp);
      end
      check("osc ctl", osc_ctl_q, 3'b011);
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      wait_set(1'b1, n);
      check("wake delay", n, 6);
      // unlock window expiry and no extension
      wr(8'h61, 8'h80);
      rdchk("unlock set", 8'he0, 8'h10, 8'h10);
      rdchk("unlock gone", 8'he0, 8'h10, 8'h00);
      wr(8'h61, 8'h02);
      rdchk("late value", 8'h61, 8'hff, 8'h03);
      wr(8'h61, 8'h80);
      wr(8'h61, 8'h80);
      rdchk("no extend", 8'he0, 8'h10, 8'h00);
      wr(8'h61, 8'h81);
      wr(8'h61, 8'h02);
      rdchk("bad unlock", 8'h61, 8'hff, 8'h03);
      // division codes 0 to 9; code 9 checks the clamp of codes above 8 to 256
      old = 8;
      for (int c = 0; c < 10; c++)
      begin
         nw = (c > 8) ? 256 : (1 << c);
         wr(8'h61, 8'h80);
         wr(8'h61, c[7:0]);
         tick_gap(g, p);
         repeat (2)
         begin
            tick_gap(g, p);
            check("switch gap", g >= (old < nw ? old : nw) && g <= (old > nw ? old : nw),
                  1'b1);
         end
         tick_gap(g, p);
         check("tick gap", g, nw);
         tick_gap(g, q);
         check("pin follows", q, !p);
         old = nw;
      end
      wr(8'he1, 8'h03);
      check("pll mult", pll_mult_q, 3'h6);
      repeat (2)
      begin
         p = pll_ref_q;
         n = 0;
         while (pll_ref_q === p && n < 20)
         begin
            @(posedge clk);
            #1;
            n++;
         end
      end
      check("pll ref", n, 3);
      for (int s = 0; s < 4; s++)
      begin
         f = '{src: 4'h5, startup_time_fuses: s[1:0], div8: 1'b0, clock_output_fuse: 1'b1};
         do_reset(f, 1'b1, ext[s]);
         rdchk("div reset", 8'h61, 8'hff, 8'h00);
         rdchk("status", 8'he0, 8'h0f, {4'h0, s[1:0], 2'b11});
         rdchk("sel ext", 8'hd0, 8'hff, 8'h05);
      end
      stop_test();
   end
endmodule
